//--- design/feis_consts.vh
`ifndef FEIS_CONSTS_VH
`define FEIS_CONSTS_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define FEIS_IDX_FIRST_LEVEL 8'h69
`define FEIS_IDX_COMM_ERR 8'h6A
`define FEIS_ADDR_FIRST_LEVEL 12'h1A4
`define FEIS_ADDR_COMM_ERR 12'h1A8

// ----------------------------------------
// reset values
// ----------------------------------------
`define FEIS_RST_FIRST_LEVEL 8'h00
`define FEIS_RST_COMM_ERR 8'h00

// ----------------------------------------
// first-level field positions
// ----------------------------------------
`define FEIS_BIT_WD 7
`define FEIS_BIT_ESM 6
`define FEIS_BIT_RDBK 5
`define FEIS_BIT_COMM 4
`define FEIS_BIT_PROC_RAIL 3
`define FEIS_BIT_CTRL_RAIL 2
`define FEIS_BIT_ORD_SHDN 1
`define FEIS_BIT_IMM_SHDN 0

// ----------------------------------------
// communication error field positions
// ----------------------------------------
`define FEIS_BIT_FRAME_ERR 0
`define FEIS_COMM_W1C_MASK 8'hAB

`endif

//--- design/feis_w1c_bank.v
`include "feis_consts.vh"

// bank of latched flags: set wins over a write-one clear
module feis_w1c_bank #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // event and clear controls
    input wire [WIDTH-1:0] set_pulse,
    input wire [WIDTH-1:0] clr_mask,
    // stored flags
    output reg [WIDTH-1:0] flags_q
);

    wire [WIDTH-1:0] flags_d;

    // set wins; zero bits of the clear keep the value
    assign flags_d = (flags_q & ~clr_mask) | set_pulse;

    // flag storage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= {WIDTH{1'b0}};
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

//--- design/feis_top.v
// Notes on behaviour
// - first-level register at 0x69, resets zero
// - bit 7 mirrors watchdog pending status
// - bit 7 drops once three watchdog flags clear
// - bit 6 follows signal-monitor register nonzero
// - bit 5 follows readback register nonzero
// - bit 4 set while comm register nonzero
// - bit 4 clears with the comm register; first-level writes cannot clear
// - bit 3 latches processor rail fault
// - bit 2 latches controller rail fault
// - bit 1 latches orderly shutdown
// - bit 0 latches immediate shutdown
// - comm error register at 0x6A, resets zero
// - comm bit 0 latches frame error, W1C
`include "feis_consts.vh"

module feis_top (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // source register summaries (same clock domain)
    input wire watchdog_reset_flag,
    input wire watchdog_fail_flag,
    input wire watchdog_long_window_timeout_flag,
    input wire [7:0] signal_monitor_source_reg,
    input wire [7:0] readback_source_reg,
    // error events, one-cycle pulses (same clock domain)
    input wire processor_rail_fault_evt,
    input wire controller_rail_fault_evt,
    input wire orderly_shutdown_evt,
    input wire immediate_shutdown_evt,
    input wire [7:0] comm_error_evt,
    // register views
    output reg [7:0] first_level_error_flags,
    output reg [7:0] communication_error_flags
);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // aligned word address match
    function addr_hit;
        input [11:0] addr;
        input [11:0] target;
        begin
            addr_hit = (addr[11:2] == target[11:2]);
        end
    endfunction

    wire acc_phase;
    wire wr_en;
    wire hit_first;
    wire hit_comm;
    wire wr_lane0;
    wire wr_done;

    assign acc_phase = psel & penable;
    assign hit_first = addr_hit(paddr, `FEIS_ADDR_FIRST_LEVEL);
    assign hit_comm = addr_hit(paddr, `FEIS_ADDR_COMM_ERR);
    assign wr_lane0 = pwrite & pstrb[0];
    assign wr_en = acc_phase & ~pready;
    // writes act only at the edge that completes the transfer
    assign wr_done = acc_phase & pready;

    // ----------------------------------------
    // latched flags
    // ----------------------------------------
    wire [3:0] fl_set;
    wire [3:0] fl_clr;
    wire [3:0] fl_q;
    wire [7:0] cm_clr;
    wire [7:0] cm_q;

    // latched events of the first-level register
    assign fl_set = {processor_rail_fault_evt,
                     controller_rail_fault_evt,
                     orderly_shutdown_evt,
                     immediate_shutdown_evt};
    // only ones in the low nibble clear; summary bits ignored
    assign fl_clr = (wr_done & wr_lane0 & hit_first) ?
                    pwdata[3:0] : 4'h0;

    // comm register: W1C only on latched bit positions
    assign cm_clr = (wr_done & wr_lane0 & hit_comm) ?
                    (pwdata[7:0] & `FEIS_COMM_W1C_MASK) : 8'h00;

    feis_w1c_bank #(
        .WIDTH(4)
    ) u_first_bank (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(fl_set),
        .clr_mask(fl_clr),
        .flags_q(fl_q)
    );

    feis_w1c_bank #(
        .WIDTH(8)
    ) u_comm_bank (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(comm_error_evt & `FEIS_COMM_W1C_MASK),
        .clr_mask(cm_clr),
        .flags_q(cm_q)
    );

    // ----------------------------------------
    // summary flags
    // ----------------------------------------
    wire wd_sum;
    wire esm_sum;
    wire rdbk_sum;
    wire comm_sum;

    // watchdog summary holds until all three flags clear
    assign wd_sum = watchdog_reset_flag | watchdog_fail_flag |
                    watchdog_long_window_timeout_flag;
    assign esm_sum = |signal_monitor_source_reg;
    assign rdbk_sum = |readback_source_reg;
    // derived from stored comm flags, no write path
    assign comm_sum = |cm_q;

    wire [7:0] first_level_d;

    assign first_level_d = {wd_sum, esm_sum, rdbk_sum, comm_sum, fl_q};

    // ----------------------------------------
    // register views
    // ----------------------------------------
    // registered copies drive the outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_level_error_flags <= `FEIS_RST_FIRST_LEVEL;
            communication_error_flags <= `FEIS_RST_COMM_ERR;
        end else begin
            first_level_error_flags <= first_level_d;
            communication_error_flags <= cm_q;
        end
    end

    // ----------------------------------------
    // apb response
    // ----------------------------------------
    // one wait state, error on unmapped address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (wr_en) begin
            pready <= 1'b1;
            pslverr <= ~(hit_first | hit_comm);
            if (pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (hit_first) begin
                prdata <= {24'h00_0000, first_level_d};
            end else if (hit_comm) begin
                prdata <= {24'h00_0000, cm_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

endmodule

//--- sim/feis_chk_asserts.sv
module feis_chk (
    // bus and sources
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire watchdog_reset_flag,
    input wire watchdog_fail_flag,
    input wire watchdog_long_window_timeout_flag,
    input wire [7:0] signal_monitor_source_reg,
    input wire [7:0] readback_source_reg,
    input wire processor_rail_fault_evt,
    input wire controller_rail_fault_evt,
    input wire orderly_shutdown_evt,
    input wire immediate_shutdown_evt,
    input wire [7:0] comm_error_evt,
    // register views
    input wire [7:0] first_level_error_flags,
    input wire [7:0] communication_error_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // short aliases
    wire [7:0] fl = first_level_error_flags;
    wire [7:0] ce = communication_error_flags;
    wire wd = watchdog_reset_flag | watchdog_fail_flag
        | watchdog_long_window_timeout_flag;
    AST_WD: assert property (fl[7] == $past(wd))
        else $error("watchdog summary wrong");
    wire sm_any = |signal_monitor_source_reg;
    AST_ESM: assert property (fl[6] == $past(sm_any))
        else $error("monitor summary wrong");
    AST_RB: assert property (fl[5] == $past(|readback_source_reg))
        else $error("readback summary wrong");
    AST_COMM: assert property (fl[4] == |ce)
        else $error("comm summary wrong");
    wire pf = processor_rail_fault_evt;
    wire cf = controller_rail_fault_evt;
    AST_PROC: assert property (pf |-> ##2 fl[3])
        else $error("processor fault not latched");
    AST_CTRL: assert property (cf |-> ##2 fl[2])
        else $error("controller fault not latched");
    AST_ORD: assert property (orderly_shutdown_evt |-> ##2 fl[1])
        else $error("orderly shutdown not latched");
    AST_IMM: assert property (immediate_shutdown_evt |-> ##2 fl[0])
        else $error("immediate shutdown not latched");
    AST_FRM: assert property (comm_error_evt[0] |-> ##2 ce[0])
        else $error("frame error not latched");
    wire clr3 = psel && penable && pwrite && pwdata[3];
    AST_HOLD: assert property ($fell(fl[3]) |-> $past(clr3, 2))
        else $error("latched flag dropped without write");
endmodule
bind feis_top feis_chk chk_u (.*);

//--- sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] ev, lat;
    logic [2:0] wd;
    logic [7:0] sm, rb, cev, cm, fl_v, cm_v;
    logic [3:0] strb;
    int error_cnt, n_tests, cyc;
    feis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_reset_flag(wd[0]),
        .watchdog_fail_flag(wd[1]),
        .watchdog_long_window_timeout_flag(wd[2]),
        .signal_monitor_source_reg(sm), .readback_source_reg(rb),
        .processor_rail_fault_evt(ev[3]), .controller_rail_fault_evt(ev[2]),
        .orderly_shutdown_evt(ev[1]), .immediate_shutdown_evt(ev[0]),
        .comm_error_evt(cev), .first_level_error_flags(fl_v),
        .communication_error_flags(cm_v));
    // clock and timeout
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    function automatic logic [31:0] exp1();
        return {24'h0, |wd, |sm, |rb, |cm, lat};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] e, input logic [7:0] c);
        @(posedge pclk);
        ev <= e;
        cev <= c;
        @(posedge pclk);
        ev <= 4'h0;
        cev <= 8'h00;
        lat |= e;
        cm |= c & 8'hAB;
    endtask
    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ev, lat, wd, sm, rb, cev, cm} = '0;
        strb = 4'hF;
        rd = $urandom(32'hD6640300);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h1A4, 0); chk(rd, 0);
        apb(0, 12'h1A8, 0); chk(rd, 0);
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            wd <= (i == 9) ? 3'h0 : 3'($urandom);
            sm <= ($urandom % 2) ? 8'($urandom) : 8'h00;
            rb <= ($urandom % 2) ? 8'($urandom) : 8'h00;
            apb(0, 12'h1A4, 0); chk(rd, exp1());
            chk({24'h0, fl_v}, exp1());
        end
        $display("summary test done");
        for (int i = 0; i < 4; i++) begin
            pulse(4'(1 << i), 8'h00);
            apb(1, 12'h1A4, 32'hF0);
            apb(0, 12'h1A4, 0); chk(rd, exp1());
            apb(1, 12'h1A4, 32'(1 << i));
            lat[i] = 1'b0;
            apb(0, 12'h1A4, 0); chk(rd, exp1());
            chk({24'h0, fl_v}, exp1());
        end
        pulse(4'h1, 8'h00);
        strb <= 4'hE;
        apb(1, 12'h1A4, 32'h01);
        strb <= 4'hF;
        apb(0, 12'h1A4, 0); chk(rd, exp1());
        apb(1, 12'h1A4, 32'h01);
        lat[0] = 1'b0;
        apb(0, 12'h1A4, 0); chk(rd, exp1());
        $display("latch test done");
        pulse(4'h0, 8'($urandom) | 8'h01);
        apb(0, 12'h1A8, 0); chk(rd, {24'h0, cm});
        chk({24'h0, cm_v}, {24'h0, cm});
        apb(1, 12'h1A4, 32'h10);
        apb(0, 12'h1A4, 0); chk(rd, exp1());
        apb(1, 12'h1A8, 32'hFF);
        cm = 8'h00;
        apb(0, 12'h1A4, 0); chk(rd, exp1());
        apb(0, 12'h1B0, 0); chk({31'h0, err}, 1);
        $display("comm test done");
        stop_test();
    end
endmodule
